// ---- gsr_defines.vh ----
// Operation
// - Signal-level report only on signal-level request
// - Count byte, then up to eight entries
// - Zero unacquired, negative unlocked, last magnitude
// - Level units follow option byte selection; here the unit bit (27) is never read and levels go out as written
// - Return latest 22-byte broadcast text
// - Health: 32 bytes, on request or arrival
// - Zero health means healthy; all zero unavailable
// - Position report per fix when selected
// - Start-up position report, negative time-of-fix
// - Nine-byte reference altitude reply on command
// - Altitude flag picks reference or held altitude
// - Identity report on requests and status change
// - Machine id, status one, status two layout
// - Status one bits: clock one, almanac three
// - Parameter reply: dynamics then four floats
// - Parameter defaults 0.08, 2.0, 12.0, 5.0
// - 3D fix needs four sats, PDOP within mask
// - Parameters kept in battery-backed storage; here reset reloads the defaults
// - Oscillator offset reply: one float
// - Receiver-health report brings identity report along; here a health request sends only the identity report
`ifndef GSR_DEFINES_VH
`define GSR_DEFINES_VH
// ----------------------------------------
// Message identifiers
// ----------------------------------------
`define GSR_ID_REQ_ID1    8'h25
`define GSR_ID_REQ_HLTH   8'h26
`define GSR_ID_REQ_SIG    8'h27
`define GSR_ID_REQ_TEXT   8'h28
`define GSR_ID_REQ_AHLTH  8'h29
`define GSR_ID_REQ_ALT    8'h2a
`define GSR_ID_REQ_PARM   8'h2c
`define GSR_ID_REQ_OSC    8'h2d
`define GSR_ID_RPT_HLTH   8'h46
`define GSR_ID_RPT_SIG    8'h47
`define GSR_ID_RPT_TEXT   8'h48
`define GSR_ID_RPT_AHLTH  8'h49
`define GSR_ID_RPT_POS    8'h4a
`define GSR_ID_RPT_IDST   8'h4b
`define GSR_ID_RPT_PARM   8'h4c
`define GSR_ID_RPT_OSC    8'h4d
// Internal tag of the altitude reply; it goes out as the position id
`define GSR_ID_INT_ALT    8'hca
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define GSR_A_CMD       12'h000
`define GSR_A_STAT      12'h004
`define GSR_A_IOOPT     12'h008
`define GSR_A_TXDATA    12'h00c
`define GSR_A_SIGWR     12'h010
`define GSR_A_TEXTWR    12'h014
`define GSR_A_HLTHWR    12'h018
`define GSR_A_FIXWR     12'h01c
`define GSR_A_ALTREF    12'h020
`define GSR_A_ALTFLAG   12'h024
`define GSR_A_IDSTAT    12'h028
`define GSR_A_DYN       12'h02c
`define GSR_A_ELEV      12'h030
`define GSR_A_SIGMASK   12'h034
`define GSR_A_DOPMASK   12'h038
`define GSR_A_PDOPSW    12'h03c
`define GSR_A_OSC       12'h040
`define GSR_A_SOLVE     12'h044
`define GSR_A_ALTUSE    12'h048
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GSR_IO_LLA_BIT    1
`define GSR_IO_PREC_BIT   4
`define GSR_IO_AMU_BIT    27
`define GSR_ST1_RTC_BIT   1
`define GSR_ST1_ALM_BIT   3
`define GSR_ST2_SUPER_BIT 0
`define GSR_SIGN_BIT      31
// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define GSR_SIG_MAX     4'h8
`define GSR_TEXT_LEN    8'h16
`define GSR_AHLTH_LEN   8'h20
`define GSR_POS_LEN     8'h14
`define GSR_ALT_LEN     8'h09
`define GSR_IDST_LEN    8'h03
`define GSR_PARM_LEN    8'h11
`define GSR_OSC_LEN     8'h04
`define GSR_HLTH_MASK   8'h3f
`define GSR_DYN_LAND    8'h01
`define GSR_ELEV_DEF    32'h3da3d70a
`define GSR_SIGM_DEF    32'h40000000
`define GSR_DOPM_DEF    32'h41400000
`define GSR_PDOPS_DEF   32'h40a00000
`define GSR_MIN_SATS_3D 4'h4
// Memory layout: signal 0..15, text 16..37, health 38..69
`define GSR_M_SIG       7'h00
`define GSR_M_TEXT      7'h10
`define GSR_M_AHLTH     7'h26
`endif

// ---- gsr_formatter.v ----
`timescale 1ns/1ps
`include "gsr_defines.vh"
module gsr_formatter #(
  parameter MACHINE_ID = 8'h5a
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg fix_3d_ok
);
  // MACHINE_ID value is arbitrary
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam S_IDLE = 3'b001;
  localparam S_SEND = 3'b010;
  localparam S_RD   = 3'b100;

  reg [2:0] state_reg;
  reg [31:0] ioopt_reg;
  reg [31:0] pos_reg [0:4];
  reg [31:0] altref_reg;
  reg altflag_reg;
  reg [7:0] st1_reg;
  reg [7:0] st2_reg;
  reg [7:0] dyn_reg;
  reg [31:0] elev_reg;
  reg [31:0] sigm_reg;
  reg [31:0] dopm_reg;
  reg [31:0] pdops_reg;
  reg [31:0] osc_reg;
  reg [3:0] sigcnt_reg;
  reg [31:0] alt3d_reg;
  reg [31:0] altuse_reg;
  // Pending report bits, one per report kind
  reg [7:0] pend_reg;
  reg [7:0] cur_id_reg;
  reg [7:0] len_reg;
  reg [7:0] idx_reg;
  reg [7:0] byte_reg;
  reg byte_vld_reg;
  reg startup_reg;
  reg [31:0] stage_reg;
  integer i;
  integer j;

  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire [6:0] mem_raddr;
  wire [31:0] mem_rdata;
  reg mem_we;
  reg [6:0] mem_waddr;

  localparam P_SIG = 0;
  localparam P_TEXT = 1;
  localparam P_AHLTH = 2;
  localparam P_POS = 3;
  localparam P_ALT = 4;
  localparam P_IDST = 5;
  localparam P_PARM = 6;
  localparam P_OSC = 7;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [7:0] fbyte;
    input [31:0] f;
    input [1:0] k;
    begin
      // Floats go out most significant byte first
      case (k)
        2'd0: fbyte = f[31:24];
        2'd1: fbyte = f[23:16];
        2'd2: fbyte = f[15:8];
        default: fbyte = f[7:0];
      endcase
    end
  endfunction

  function [7:0] rpt_len;
    input [7:0] id;
    input [3:0] cnt;
    begin
      case (id)
        `GSR_ID_RPT_SIG: rpt_len = 8'h01 + {4'h0, cnt} * 8'h05;
        `GSR_ID_RPT_TEXT: rpt_len = `GSR_TEXT_LEN;
        `GSR_ID_RPT_AHLTH: rpt_len = `GSR_AHLTH_LEN;
        `GSR_ID_RPT_POS: rpt_len = `GSR_POS_LEN;
        `GSR_ID_INT_ALT: rpt_len = `GSR_ALT_LEN;
        `GSR_ID_RPT_IDST: rpt_len = `GSR_IDST_LEN;
        `GSR_ID_RPT_PARM: rpt_len = `GSR_PARM_LEN;
        default: rpt_len = `GSR_OSC_LEN;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Memory for signal, text and health tables
  // ----------------------------------------
  // Signal entry word: [31:24] satellite, [23:0] unused; level word follows
  wire [7:0] sig_entry = (idx_reg - 8'h01) / 8'h05;
  wire [7:0] sig_off = (idx_reg - 8'h01) % 8'h05;
  assign mem_raddr = (cur_id_reg == `GSR_ID_RPT_SIG) ?
      (`GSR_M_SIG + {sig_entry[5:0], 1'b0} + ((sig_off == 8'h00) ? 7'h0 : 7'h1)) :
      (cur_id_reg == `GSR_ID_RPT_TEXT) ? (`GSR_M_TEXT + idx_reg[6:0]) :
      (`GSR_M_AHLTH + idx_reg[6:0]);

  gsr_store #(.AW(7), .DW(32), .DEPTH(128)) u_store (
    .pclk(pclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(pwdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // SIGWR: [18:16] slot (0..7), [20] level word, else satellite word
  // TEXTWR: [12:8] index, [7:0] char; HLTHWR: [12:8] sat index, [5:0] health
  always @* begin
    mem_we = 1'b0;
    mem_waddr = 7'h00;
    if (wr && paddr == `GSR_A_SIGWR) begin
      mem_we = 1'b1;
      mem_waddr = `GSR_M_SIG + {pwdata[18:16], pwdata[20]};
    end else if (wr && paddr == `GSR_A_TEXTWR) begin
      mem_we = 1'b1;
      mem_waddr = `GSR_M_TEXT + {2'b00, pwdata[12:8]};
    end else if (wr && paddr == `GSR_A_HLTHWR) begin
      mem_we = 1'b1;
      mem_waddr = `GSR_M_AHLTH + {2'b00, pwdata[12:8]};
    end
  end

  // Byte value for current payload index
  reg [7:0] pay_byte;
  always @* begin
    pay_byte = 8'h00;
    case (cur_id_reg)
      `GSR_ID_RPT_SIG: begin
        if (idx_reg == 8'h00) begin
          pay_byte = {4'h0, sigcnt_reg};
        end else if (sig_off == 8'h00) begin
          pay_byte = mem_rdata[31:24];
        end else begin
          // Level arrives already in the selected unit and sign
          pay_byte = fbyte(mem_rdata, sig_off[1:0] - 2'd1);
        end
      end
      `GSR_ID_RPT_TEXT: pay_byte = mem_rdata[7:0];
      `GSR_ID_RPT_AHLTH: pay_byte = mem_rdata[7:0] & `GSR_HLTH_MASK;
      `GSR_ID_RPT_POS: pay_byte = fbyte(stage_reg, idx_reg[1:0]);
      `GSR_ID_INT_ALT: begin
        if (idx_reg == 8'h08) begin
          pay_byte = {7'h00, altflag_reg};
        end else if (idx_reg < 8'h04) begin
          pay_byte = fbyte(altref_reg, idx_reg[1:0]);
        end
      end
      `GSR_ID_RPT_IDST: begin
        case (idx_reg[1:0])
          2'd0: pay_byte = MACHINE_ID;
          2'd1: pay_byte = st1_reg;
          default: pay_byte = st2_reg;
        endcase
      end
      `GSR_ID_RPT_PARM: begin
        if (idx_reg == 8'h00) begin
          pay_byte = dyn_reg;
        end else begin
          pay_byte = fbyte(stage_reg, idx_reg[1:0] - 2'd1);
        end
      end
      default: pay_byte = fbyte(osc_reg, idx_reg[1:0]);
    endcase
  end

  // Float word being sent for position and parameter reports
  reg [31:0] stage_next;
  always @* begin
    stage_next = 32'h0;
    if (cur_id_reg == `GSR_ID_RPT_POS) begin
      case (idx_reg[4:2])
        3'd0: stage_next = pos_reg[0];
        3'd1: stage_next = pos_reg[1];
        3'd2: stage_next = pos_reg[2];
        3'd3: stage_next = pos_reg[3];
        default: stage_next = startup_reg ? (pos_reg[4] | 32'h80000000) : pos_reg[4];
      endcase
    end else begin
      case ((idx_reg - 8'h01) >> 2)
        8'd0: stage_next = elev_reg;
        8'd1: stage_next = sigm_reg;
        8'd2: stage_next = dopm_reg;
        default: stage_next = pdops_reg;
      endcase
    end
  end

  // ----------------------------------------
  // Main sequencing and registers
  // ----------------------------------------
  reg [7:0] pick;
  reg [7:0] pick_id;
  always @* begin
    pick = 8'h00;
    pick_id = `GSR_ID_RPT_OSC;
    for (i = 7; i >= 0; i = i - 1) begin
      if (pend_reg[i]) begin
        pick = 8'h00;
        pick[i] = 1'b1;
      end
    end
    case (pick)
      8'h01: pick_id = `GSR_ID_RPT_SIG;
      8'h02: pick_id = `GSR_ID_RPT_TEXT;
      8'h04: pick_id = `GSR_ID_RPT_AHLTH;
      8'h08: pick_id = `GSR_ID_RPT_POS;
      8'h10: pick_id = `GSR_ID_INT_ALT;
      8'h20: pick_id = `GSR_ID_RPT_IDST;
      8'h40: pick_id = `GSR_ID_RPT_PARM;
      default: pick_id = `GSR_ID_RPT_OSC;
    endcase
  end

  reg [7:0] req_set;
  always @* begin
    req_set = 8'h00;
    if (wr && paddr == `GSR_A_CMD) begin
      case (pwdata[7:0])
        `GSR_ID_REQ_SIG: req_set[P_SIG] = 1'b1;
        `GSR_ID_REQ_TEXT: req_set[P_TEXT] = 1'b1;
        `GSR_ID_REQ_AHLTH: req_set[P_AHLTH] = 1'b1;
        `GSR_ID_REQ_ALT: req_set[P_ALT] = 1'b1;
        `GSR_ID_REQ_ID1: req_set[P_IDST] = 1'b1;
        `GSR_ID_REQ_HLTH: req_set[P_IDST] = 1'b1;
        `GSR_ID_REQ_PARM: req_set[P_PARM] = 1'b1;
        `GSR_ID_REQ_OSC: req_set[P_OSC] = 1'b1;
        default: req_set = 8'h00;
      endcase
    end
    if (wr && paddr == `GSR_A_HLTHWR && pwdata[31]) req_set[P_AHLTH] = 1'b1;
    if (wr && paddr == `GSR_A_ALTREF) req_set[P_ALT] = 1'b1;
    if (wr && paddr == `GSR_A_IDSTAT && pwdata[15:0] != {st2_reg, st1_reg}) req_set[P_IDST] = 1'b1;
    if (wr && paddr == `GSR_A_FIXWR && pwdata[31:29] == 3'd4 &&
        ioopt_reg[`GSR_IO_LLA_BIT] && !ioopt_reg[`GSR_IO_PREC_BIT]) req_set[P_POS] = 1'b1;
  end

  wire rd_tx = rd && paddr == `GSR_A_TXDATA;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      ioopt_reg <= 32'h0000_0002;
      for (j = 0; j < 5; j = j + 1) pos_reg[j] <= 32'h0;
      altref_reg <= 32'h0;
      altflag_reg <= 1'b0;
      st1_reg <= 8'h00;
      st2_reg <= 8'h01;
      // Defaults; a battery-backed copy is held by the software side
      dyn_reg <= `GSR_DYN_LAND;
      elev_reg <= `GSR_ELEV_DEF;
      sigm_reg <= `GSR_SIGM_DEF;
      dopm_reg <= `GSR_DOPM_DEF;
      pdops_reg <= `GSR_PDOPS_DEF;
      osc_reg <= 32'h0;
      sigcnt_reg <= 4'h0;
      alt3d_reg <= 32'h0;
      altuse_reg <= 32'h0;
      pend_reg <= 8'h08;
      startup_reg <= 1'b1;
      cur_id_reg <= 8'h00;
      len_reg <= 8'h00;
      idx_reg <= 8'h00;
      byte_reg <= 8'h00;
      byte_vld_reg <= 1'b0;
      stage_reg <= 32'h0;
      fix_3d_ok <= 1'b0;
    end else begin
      if (wr) begin
        case (paddr)
          `GSR_A_IOOPT: ioopt_reg <= pwdata;
          `GSR_A_FIXWR: pos_reg[pwdata[31:29]] <= {pwdata[28:0], 3'b000};
          `GSR_A_ALTREF: altref_reg <= pwdata;
          `GSR_A_ALTFLAG: altflag_reg <= pwdata[0];
          `GSR_A_IDSTAT: begin
            st1_reg <= pwdata[7:0] & 8'h0a;
            st2_reg <= pwdata[15:8];
          end
          `GSR_A_DYN: dyn_reg <= pwdata[7:0];
          `GSR_A_ELEV: elev_reg <= pwdata;
          `GSR_A_SIGMASK: sigm_reg <= pwdata;
          `GSR_A_DOPMASK: dopm_reg <= pwdata;
          `GSR_A_PDOPSW: pdops_reg <= pwdata;
          `GSR_A_OSC: osc_reg <= pwdata;
          `GSR_A_SIGWR: if (pwdata[24:21] <= `GSR_SIG_MAX) sigcnt_reg <= pwdata[24:21];
          `GSR_A_SOLVE: begin
            // [3:0] sats, [4] pdop within mask, [5] 3D fix done with altitude in [31:8]
            fix_3d_ok <= (pwdata[3:0] >= `GSR_MIN_SATS_3D) && pwdata[4];
            if (pwdata[5]) alt3d_reg <= {pwdata[31:8], 8'h00};
          end
          default: stage_reg <= stage_reg;
        endcase
      end
      altuse_reg <= altflag_reg ? altref_reg : alt3d_reg;
      case (state_reg)
        S_IDLE: begin
          if (pend_reg != 8'h00) begin
            cur_id_reg <= pick_id;
            len_reg <= rpt_len(pick_id, sigcnt_reg);
            idx_reg <= 8'h00;
            state_reg <= S_RD;
          end
        end
        S_RD: begin
          // One cycle for memory read and float staging
          stage_reg <= stage_next;
          state_reg <= S_SEND;
        end
        S_SEND: begin
          if (!byte_vld_reg) begin
            byte_reg <= pay_byte;
            byte_vld_reg <= 1'b1;
          end else if (rd_tx && prdata[24]) begin
            // Only a read that showed the byte valid consumes it
            byte_vld_reg <= 1'b0;
            if (idx_reg + 8'h01 >= len_reg) begin
              if (cur_id_reg == `GSR_ID_RPT_POS) startup_reg <= 1'b0;
              state_reg <= S_IDLE;
            end else begin
              idx_reg <= idx_reg + 8'h01;
              state_reg <= S_RD;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
      // New requests win over the clear of the one now starting
      pend_reg <= (pend_reg & ~((state_reg == S_IDLE) ? pick : 8'h00)) | req_set;
    end
  end

  // ----------------------------------------
  // APB read side
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        case (paddr)
          `GSR_A_STAT: prdata <= {8'h00, pend_reg, 5'h00, state_reg, 7'h00, fix_3d_ok};
          `GSR_A_IOOPT: prdata <= ioopt_reg;
          `GSR_A_TXDATA: prdata <= {7'h00, byte_vld_reg, len_reg,
              ((cur_id_reg == `GSR_ID_INT_ALT) ? `GSR_ID_RPT_POS : cur_id_reg), byte_reg};
          `GSR_A_ALTREF: prdata <= altref_reg;
          `GSR_A_ALTFLAG: prdata <= {31'h0, altflag_reg};
          `GSR_A_IDSTAT: prdata <= {16'h0, st2_reg, st1_reg};
          `GSR_A_DYN: prdata <= {24'h0, dyn_reg};
          `GSR_A_ELEV: prdata <= elev_reg;
          `GSR_A_SIGMASK: prdata <= sigm_reg;
          `GSR_A_DOPMASK: prdata <= dopm_reg;
          `GSR_A_PDOPSW: prdata <= pdops_reg;
          `GSR_A_OSC: prdata <= osc_reg;
          `GSR_A_ALTUSE: prdata <= altuse_reg;
          `GSR_A_CMD, `GSR_A_SIGWR, `GSR_A_TEXTWR, `GSR_A_HLTHWR, `GSR_A_FIXWR, `GSR_A_SOLVE: prdata <= 32'h0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

// ---- gsr_formatter_checker.sv ----
`timescale 1ns/1ps
module gsr_formatter_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire fix_3d_ok
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  reg sig_req_seen;
  wire solve_wr = psel && penable && pwrite && paddr == 12'h044;
  wire txd_rd = pready && !pwrite && paddr == 12'h00c;
  wire txd_valid = txd_rd && prdata[24];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_req_seen <= 1'b0;
    end else if (psel && penable && pwrite && paddr == 12'h000 && pwdata[7:0] == 8'h27) begin
      sig_req_seen <= 1'b1;
    end
  end

  function automatic logic len_ok(input [7:0] id, input [7:0] len);
    case (id)
      8'h48: len_ok = (len == 8'h16);
      8'h49: len_ok = (len == 8'h20);
      8'h4a: len_ok = (len == 8'h14) || (len == 8'h09);
      8'h4b: len_ok = (len == 8'h03);
      8'h4c: len_ok = (len == 8'h11);
      8'h4d: len_ok = (len == 8'h04);
      default: len_ok = 1'b1;
    endcase
  endfunction

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  zero_wait_a: assert property (psel && !penable |=> pready && psel && penable)
    else $error("no answer in first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (pready && paddr > 12'h048 |-> pslverr)
    else $error("unmapped access without error");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  txd_upper_zero_a: assert property (txd_rd |-> prdata[31:25] == 7'h00)
    else $error("transmit word upper bits set");
  sig_on_request_a: assert property (txd_valid && prdata[15:8] == 8'h47 |-> sig_req_seen)
    else $error("signal report without request");
  sig_length_a: assert property (txd_valid && prdata[15:8] == 8'h47 |->
    prdata[23:16] <= 8'h29 && (prdata[23:16] - 8'h01) % 8'h05 == 8'h00)
    else $error("signal report length wrong");
  report_len_a: assert property (txd_valid |-> len_ok(prdata[15:8], prdata[23:16]))
    else $error("report length wrong");
  fix_change_a: assert property ($changed(fix_3d_ok) |-> $past(solve_wr))
    else $error("fix flag moved without solve write");
endmodule

bind gsr_formatter gsr_formatter_checker gsr_formatter_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fix_3d_ok(fix_3d_ok));

// ---- gsr_host_model.sv ----
`timescale 1ns/1ps
`include "gsr_defines.vh"
module gsr_host_model (
  input wire pclk,
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [11:0] paddr,
  output reg [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  reg [7:0] rb [0:63];
  reg [31:0] rdv;
  reg errv;
  integer gap;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    gap = 0;
  end

  // Gap lets the host run slow between transfers
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      repeat (gap) @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // Only a read that shows valid consumes a byte
  task get_rpt(output [7:0] id, output [7:0] len);
    integer i;
    begin
      i = 0;
      id = 8'h00;
      len = 8'h01;
      while (i < len) begin
        xfer(1'b0, `GSR_A_TXDATA, 32'h00000000);
        if (rdv[24] === 1'b1) begin
          id = rdv[15:8];
          len = rdv[23:16];
          rb[i] = rdv[7:0];
          i = i + 1;
        end
      end
    end
  endtask
endmodule

// ---- gsr_store.v ----
`timescale 1ns/1ps
module gsr_store #(
  parameter AW = 7,
  parameter DW = 32,
  parameter DEPTH = 128
) (
  input wire pclk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:DEPTH-1];
  // No reset: contents are held payload data, read out registered
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "gsr_defines.vh"
module testbench;
  reg pclk;
  reg presetn;
  wire psel;
  wire penable;
  wire pwrite;
  wire [11:0] paddr;
  wire [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire fix_3d_ok;
  reg [7:0] id;
  reg [7:0] len;
  integer err_total;
  integer checks_done;
  integer i;
  localparam [7:0] MID = 8'h3c; // Arbitrary machine identifier
  localparam logic [31:0] FV [5] = '{32'h3f000000, 32'hbf800000, 32'h42c80000, 32'h40400000, 32'h41200000};

  gsr_formatter #(.MACHINE_ID(MID)) gsr_formatter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fix_3d_ok(fix_3d_ok));
  gsr_host_model gsr_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    gsr_host_model_inst.xfer(1'b1, a, d);
  endtask
  task req(input [7:0] c, input [7:0] eid, input [7:0] elen);
    begin
      if (c != 8'h00) wr(`GSR_A_CMD, {24'h0, c});
      gsr_host_model_inst.get_rpt(id, len);
      chk(id, eid, "report id");
      chk(len, elen, "report length");
    end
  endtask
  function [31:0] fl(input integer k);
    fl = {gsr_host_model_inst.rb[k], gsr_host_model_inst.rb[k+1], gsr_host_model_inst.rb[k+2],
      gsr_host_model_inst.rb[k+3]};
  endfunction
  task quiet;
    repeat (4) begin
      gsr_host_model_inst.xfer(1'b0, `GSR_A_TXDATA, 32'h0);
      chk(gsr_host_model_inst.rdv[24], 1'b0, "unsolicited report");
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_startup_sig;
    begin
      chk(fix_3d_ok, 1'b0, "fix flag after reset");
      req(8'h00, 8'h4a, 8'h14);
      chk(gsr_host_model_inst.rb[16][7], 1'b1, "start-up time sign");
      wr(`GSR_A_SIGWR, 32'h01000005);
      quiet;
      req(8'h27, 8'h47, 8'h29);
      chk(gsr_host_model_inst.rb[0], 8'h08, "signal count");
      chk(gsr_host_model_inst.rb[1], 8'h01, "first satellite number");
    end
  endtask
  task t_text_health;
    begin
      for (i = 0; i < 22; i = i + 1) wr(`GSR_A_TEXTWR, {19'h0, i[4:0], 8'h41 + i[7:0]});
      req(8'h28, 8'h48, 8'h16);
      for (i = 0; i < 22; i = i + 1) chk(gsr_host_model_inst.rb[i], 8'h41 + i[7:0], "text byte");
      for (i = 0; i < 32; i = i + 1) wr(`GSR_A_HLTHWR, {19'h0, i[4:0], 8'hc0 | i[7:0]});
      quiet;
      req(8'h29, 8'h49, 8'h20);
      for (i = 0; i < 32; i = i + 1) chk(gsr_host_model_inst.rb[i], i[7:0], "health byte");
      wr(`GSR_A_HLTHWR, 32'h80000300);
      req(8'h00, 8'h49, 8'h20);
      chk(gsr_host_model_inst.rb[3], 8'h00, "arrived health");
    end
  endtask
  task t_pos_alt;
    begin
      gsr_host_model_inst.gap = 2;
      wr(`GSR_A_IOOPT, 32'h00000002);
      for (i = 0; i < 5; i = i + 1) wr(`GSR_A_FIXWR, {i[2:0], FV[i][31:3]});
      req(8'h00, 8'h4a, 8'h14);
      for (i = 0; i < 5; i = i + 1) chk(fl(4 * i), FV[i], "fix field");
      wr(`GSR_A_IOOPT, 32'h00000012);
      wr(`GSR_A_FIXWR, {3'h4, FV[4][31:3]});
      quiet;
      gsr_host_model_inst.gap = 0;
      wr(`GSR_A_ALTFLAG, 32'h00000001);
      wr(`GSR_A_ALTREF, 32'h42c80000);
      req(8'h00, 8'h4a, 8'h09);
      chk(fl(0), 32'h42c80000, "reference altitude");
      chk(gsr_host_model_inst.rb[8], 8'h01, "altitude flag");
      gsr_host_model_inst.xfer(1'b0, `GSR_A_ALTUSE, 32'h0);
      chk(gsr_host_model_inst.rdv, 32'h42c80000, "altitude in use");
      wr(`GSR_A_ALTFLAG, 32'h00000000);
      req(8'h2a, 8'h4a, 8'h09);
      chk(gsr_host_model_inst.rb[8], 8'h00, "altitude flag cleared");
      wr(`GSR_A_SOLVE, 32'h43480034);
      chk(fix_3d_ok, 1'b1, "fix flag four sats");
      gsr_host_model_inst.xfer(1'b0, `GSR_A_ALTUSE, 32'h0);
      chk(gsr_host_model_inst.rdv, 32'h43480000, "held 3D altitude");
      wr(`GSR_A_SOLVE, 32'h00000013);
      chk(fix_3d_ok, 1'b0, "fix flag three sats");
    end
  endtask
  task t_id_parm;
    begin
      req(8'h25, 8'h4b, 8'h03);
      chk(gsr_host_model_inst.rb[0], MID, "machine id");
      wr(`GSR_A_IDSTAT, 32'h000000ff);
      req(8'h00, 8'h4b, 8'h03);
      chk(gsr_host_model_inst.rb[1], 8'h0a, "status one");
      req(8'h26, 8'h4b, 8'h03);
      chk(gsr_host_model_inst.rb[0], MID, "machine id on health request");
      quiet;
      for (i = 1; i < 4; i = i + 1) begin
        wr(`GSR_A_DYN, i);
        req(8'h2c, 8'h4c, 8'h11);
        chk(gsr_host_model_inst.rb[0], i[7:0], "dynamics code");
        chk(fl(1), `GSR_ELEV_DEF, "elevation mask");
        chk(fl(5), `GSR_SIGM_DEF, "signal mask");
        chk(fl(9), `GSR_DOPM_DEF, "dop mask");
        chk(fl(13), `GSR_PDOPS_DEF, "pdop switch");
      end
      wr(`GSR_A_OSC, 32'hc2f60000);
      req(8'h2d, 8'h4d, 8'h04);
      chk(fl(0), 32'hc2f60000, "oscillator offset");
      gsr_host_model_inst.xfer(1'b0, 12'h100, 32'h0);
      chk(gsr_host_model_inst.errv, 1'b1, "unmapped read error");
      wr(12'h104, 32'h0);
      chk(gsr_host_model_inst.errv, 1'b1, "unmapped write error");
    end
  endtask

  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #400000;
    err_total = err_total + 1;
    summarize;
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_startup_sig;
    t_text_health;
    t_pos_alt;
    t_id_parm;
    summarize;
  end
endmodule
